// ---- verilog/i2ca_defines.svh ----
// Offsets, field positions, reset values and masks of the address and rate register block
`ifndef I2CA_DEFINES_SVH
`define I2CA_DEFINES_SVH

`define I2CA_OFS_OWN    12'h280
`define I2CA_OFS_RATE   12'h284
`define I2CA_OFS_CTRL   12'h288
`define I2CA_OFS_STAT   12'h28c
`define I2CA_OFS_DATA   12'h290

`define I2CA_BYTE_MSB   31
`define I2CA_BYTE_LSB   24
`define I2CA_RST_BYTE   8'h00

`define I2CA_OWN_MASK   8'hfe
`define I2CA_RATE_MASK  8'h3f
`define I2CA_CTRL_MASK  8'hf8

`define I2CA_CTRL_EN    7
`define I2CA_CTRL_TXAK  3

`define I2CA_STAT_DONE  7
`define I2CA_STAT_AAS   6
`define I2CA_STAT_BUSY  5
`define I2CA_STAT_SRW   2

`define I2CA_BIT_COUNT  4'h8

`endif

// ---- verilog/i2ca_pkg.sv ----
// Types shared by the address and rate register block
`default_nettype none
package i2ca_pkg;

   typedef struct packed {
      logic        sel;
      logic        wr;
      logic        ext;
      logic [11:0] ofs;
      logic [31:0] wdata;
   } i2ca_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } i2ca_resp_t;

   typedef enum logic [3:0] {
      I2CA_IDLE = 4'b0001,
      I2CA_ADDR = 4'b0010,
      I2CA_ACK  = 4'b0100,
      I2CA_DATA = 4'b1000
   } i2ca_state_t;

endpackage
`default_nettype wire

// ---- verilog/i2ca_rate_div.sv ----
// Bit-rate divider: rate code to divider, half-period tick generator
`timescale 1ns/100ps
`default_nettype none
module i2ca_rate_div (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       en,
   input  wire logic [5:0] code,
   output var  logic       tick
);
   import i2ca_pkg::*;

   localparam logic [11:0] DIV_TAB [64] = '{
      12'd28,   12'd30,   12'd34,   12'd40,   12'd44,   12'd48,   12'd56,   12'd68,
      12'd80,   12'd88,   12'd104,  12'd128,  12'd144,  12'd160,  12'd192,  12'd240,
      12'd288,  12'd320,  12'd384,  12'd480,  12'd576,  12'd640,  12'd768,  12'd960,
      12'd1152, 12'd1280, 12'd1536, 12'd1920, 12'd2304, 12'd2560, 12'd3072, 12'd3840,
      12'd20,   12'd22,   12'd24,   12'd26,   12'd28,   12'd32,   12'd36,   12'd40,
      12'd48,   12'd56,   12'd64,   12'd72,   12'd80,   12'd96,   12'd112,  12'd128,
      12'd160,  12'd192,  12'd224,  12'd256,  12'd320,  12'd384,  12'd448,  12'd512,
      12'd640,  12'd768,  12'd896,  12'd1024, 12'd1280, 12'd1536, 12'd1792, 12'd2048
   };

   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic        tick_next;
   logic [11:0] half;
   logic        wrap;

   always_comb begin
      // All dividers are even, so two ticks make one bit period
      half      = {1'b0, DIV_TAB[code][11:1]}; // R7 R8 R9 R10 R11
      wrap      = (cnt_reg >= half - 12'h001);
      cnt_next  = wrap ? 12'h000 : cnt_reg + 12'h001;
      tick_next = wrap & en;
      if (!en) begin
         cnt_next = 12'h000;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_reg <= 12'h000;
         tick    <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick    <= tick_next;
      end
   end

endmodule
`default_nettype wire

// ---- verilog/i2ca_addr_match.sv ----
// Calling-address matcher and slave byte receiver on the synchronised lines
`timescale 1ns/100ps
`default_nettype none
`include "i2ca_defines.svh"
module i2ca_addr_match (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       en,
   input  wire logic [6:0] own_addr,
   input  wire logic       txak,
   input  wire logic       scl,
   input  wire logic       sda,
   output var  logic       addressed,
   output var  logic       srw,
   output var  logic       busy,
   output var  logic       done,
   output var  logic [7:0] rx_byte,
   output var  logic       sda_oe
);
   import i2ca_pkg::*;

   i2ca_state_t state_reg, state_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic [7:0]  shf_reg, shf_next;
   logic        scl_reg, sda_reg;
   logic        addr_next, srw_next, busy_next, done_next, oe_next;
   logic [7:0]  rx_next;
   logic        rise, fall, start, stop;

   always_comb begin
      rise       = scl & ~scl_reg;
      fall       = ~scl & scl_reg;
      start      = scl & scl_reg & sda_reg & ~sda;
      stop       = scl & scl_reg & ~sda_reg & sda;
      state_next = state_reg;
      cnt_next   = cnt_reg;
      shf_next   = shf_reg;
      addr_next  = addressed;
      srw_next   = srw;
      busy_next  = busy;
      done_next  = 1'b0;
      rx_next    = rx_byte;
      oe_next    = sda_oe;
      if (start) begin
         // A repeated start drops the previous selection
         busy_next  = 1'b1;
         state_next = I2CA_ADDR;
         cnt_next   = 4'h0;
         addr_next  = 1'b0;
         oe_next    = 1'b0;
      end else if (stop) begin
         busy_next  = 1'b0;
         state_next = I2CA_IDLE;
         addr_next  = 1'b0;
         oe_next    = 1'b0;
      end else begin
         case (state_reg)
            I2CA_IDLE: begin
               oe_next = 1'b0;
            end
            I2CA_ADDR: begin
               if (rise) begin
                  shf_next = {shf_reg[6:0], sda};
                  cnt_next = cnt_reg + 4'h1;
               end
               if (fall && cnt_reg == `I2CA_BIT_COUNT) begin
                  if (en && shf_reg[7:1] == own_addr) begin // R3
                     addr_next  = 1'b1; // R5
                     srw_next   = shf_reg[0];
                     oe_next    = 1'b1;
                     state_next = I2CA_ACK;
                  end else begin
                     state_next = I2CA_IDLE;
                  end
               end
            end
            I2CA_ACK: begin
               if (fall) begin
                  oe_next    = 1'b0;
                  cnt_next   = 4'h0;
                  state_next = addressed ? I2CA_DATA : I2CA_IDLE;
               end
            end
            I2CA_DATA: begin
               if (rise) begin
                  shf_next = {shf_reg[6:0], sda};
                  cnt_next = cnt_reg + 4'h1;
               end
               if (fall && cnt_reg == `I2CA_BIT_COUNT) begin
                  rx_next    = shf_reg;
                  done_next  = 1'b1;
                  oe_next    = ~txak & ~srw;
                  state_next = I2CA_ACK;
               end
            end
            default: begin
               state_next = I2CA_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= I2CA_IDLE;
         cnt_reg   <= 4'h0;
         shf_reg   <= 8'h00;
         scl_reg   <= 1'b1;
         sda_reg   <= 1'b1;
         addressed <= 1'b0;
         srw       <= 1'b0;
         busy      <= 1'b0;
         done      <= 1'b0;
         rx_byte   <= 8'h00;
         sda_oe    <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         shf_reg   <= shf_next;
         scl_reg   <= scl;
         sda_reg   <= sda;
         addressed <= addr_next;
         srw       <= srw_next;
         busy      <= busy_next;
         done      <= done_next;
         rx_byte   <= rx_next;
         sda_oe    <= oe_next;
      end
   end

endmodule
`default_nettype wire

// ---- verilog/i2ca_top.sv ----
// Address and bit-rate register block with slave address matching
// Behaviour
// R1: Five byte registers sit at offsets 0x280 to 0x290 in steps of four, in data bits 31:24.
// R2: Outside masters may reach every register here but nothing else through this block.
// R3: The own slave address lives in bits 7:1 and is compared with each calling address.
// R4: The stored own address is never sent out as a calling address.
// R5: A calling address equal to the own address puts the block in slave mode for that transfer.
// R6: Software writes zero to own-address bit 0 and to rate-code bits 7:6.
// R7: The bit clock is the input clock divided by the divider that the six-bit rate code picks.
// R8: Codes 0x00 to 0x0f select dividers 28 up to 240 in table order.
// R9: Codes 0x10 to 0x1f select dividers 288 up to 3840 in table order.
// R10: Codes 0x20 to 0x2f select dividers 20 up to 128 in table order.
// R11: Codes 0x30 to 0x3f select dividers 160 up to 2048 in table order.
// R12: Own-address and rate registers reset to zero and reserved bits read as zero.
`timescale 1ns/100ps
`default_nettype none
`include "i2ca_defines.svh"
module i2ca_top (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire i2ca_pkg::i2ca_req_t  req,
   output var  i2ca_pkg::i2ca_resp_t resp,
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   output var  logic                 sda_o,
   output var  logic                 sda_oe,
   output var  logic                 slave_mode,
   output var  logic                 bit_tick
);
   import i2ca_pkg::*;

   function automatic logic is_mapped(input logic [11:0] ofs);
      is_mapped = (ofs == `I2CA_OFS_OWN)  || (ofs == `I2CA_OFS_RATE) ||
                  (ofs == `I2CA_OFS_CTRL) || (ofs == `I2CA_OFS_STAT) ||
                  (ofs == `I2CA_OFS_DATA);
   endfunction

   function automatic logic hit(input i2ca_req_t r, input logic [11:0] ofs);
      hit = r.sel && r.ofs == ofs;
   endfunction

   logic [7:0] own_reg, own_next;
   logic [7:0] rate_reg, rate_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] data_reg, data_next;
   logic       done_reg, done_next;
   i2ca_resp_t resp_next;
   logic       scl_meta, scl_sync;
   logic       sda_meta, sda_sync;
   logic       deny;
   logic       wr;
   logic       rd_data;
   logic [7:0] stat_byte;
   logic [7:0] rbyte;
   logic [7:0] wbyte;
   logic       en;
   logic       m_addressed, m_srw, m_busy, m_done, m_oe;
   logic [7:0] m_rx;

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         scl_meta <= scl_i;
         scl_sync <= scl_meta;
         sda_meta <= sda_i;
         sda_sync <= sda_meta;
      end
   end

   assign en = ctrl_reg[`I2CA_CTRL_EN];

   i2ca_rate_div u_rate (
      .clk     (clk),
      .reset_n (reset_n),
      .en      (en),
      .code    (rate_reg[5:0]), // R7
      .tick    (bit_tick)
   );

   // Matcher listens and drives only the acknowledge; the outgoing calling address is not sourced here
   i2ca_addr_match u_match (
      .clk       (clk),
      .reset_n   (reset_n),
      .en        (en),
      .own_addr  (own_reg[7:1]), // R3 R4
      .txak      (ctrl_reg[`I2CA_CTRL_TXAK]),
      .scl       (scl_sync),
      .sda       (sda_sync),
      .addressed (m_addressed),
      .srw       (m_srw),
      .busy      (m_busy),
      .done      (m_done),
      .rx_byte   (m_rx),
      .sda_oe    (m_oe)
   );

   always_comb begin
      // Outside masters get an error for anything beyond these five registers
      deny    = req.ext && !is_mapped(req.ofs); // R2
      wr      = req.sel && req.wr && !deny;
      rd_data = hit(req, `I2CA_OFS_DATA) && !req.wr;
      wbyte   = req.wdata[`I2CA_BYTE_MSB:`I2CA_BYTE_LSB]; // R1
      stat_byte = 8'h00;
      stat_byte[`I2CA_STAT_DONE] = done_reg;
      stat_byte[`I2CA_STAT_AAS]  = m_addressed;
      stat_byte[`I2CA_STAT_BUSY] = m_busy;
      stat_byte[`I2CA_STAT_SRW]  = m_srw;
      case (req.ofs)
         `I2CA_OFS_OWN: begin
            rbyte = own_reg;
         end
         `I2CA_OFS_RATE: begin
            rbyte = rate_reg;
         end
         `I2CA_OFS_CTRL: begin
            rbyte = ctrl_reg;
         end
         `I2CA_OFS_STAT: begin
            rbyte = stat_byte;
         end
         `I2CA_OFS_DATA: begin
            rbyte = data_reg;
         end
         default: begin
            rbyte = 8'h00;
         end
      endcase
   end

   always_comb begin
      own_next  = own_reg;
      rate_next = rate_reg;
      ctrl_next = ctrl_reg;
      data_next = data_reg;
      if (wr && hit(req, `I2CA_OFS_OWN)) begin
         own_next = wbyte & `I2CA_OWN_MASK; // R6 R12
      end
      if (wr && hit(req, `I2CA_OFS_RATE)) begin
         rate_next = wbyte & `I2CA_RATE_MASK; // R6 R12
      end
      if (wr && hit(req, `I2CA_OFS_CTRL)) begin
         // Repeat-start bit always reads zero
         ctrl_next = wbyte & `I2CA_CTRL_MASK;
      end
      // A received byte overrides a software write in the same cycle
      if (m_done) begin
         data_next = m_rx;
      end else if (wr && hit(req, `I2CA_OFS_DATA)) begin
         data_next = wbyte;
      end
      // Completion flag: set wins over the clear made by a data read
      done_next = done_reg;
      if (rd_data && !deny) begin
         done_next = 1'b0;
      end
      if (m_done) begin
         done_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         own_reg  <= `I2CA_RST_BYTE; // R12
         rate_reg <= `I2CA_RST_BYTE; // R12
         ctrl_reg <= `I2CA_RST_BYTE;
         data_reg <= `I2CA_RST_BYTE;
         done_reg <= 1'b0;
      end else begin
         own_reg  <= own_next;
         rate_reg <= rate_next;
         ctrl_reg <= ctrl_next;
         data_reg <= data_next;
         done_reg <= done_next;
      end
   end

   always_comb begin
      resp_next       = '0;
      resp_next.ack   = req.sel;
      resp_next.err   = req.sel && deny; // R2
      if (req.sel && !req.wr && !deny) begin
         // Lower three bytes are reserved and read as zero
         resp_next.rdata[`I2CA_BYTE_MSB:`I2CA_BYTE_LSB] = rbyte; // R1 R12
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         resp       <= '0;
         sda_o      <= 1'b0;
         sda_oe     <= 1'b0;
         slave_mode <= 1'b0;
      end else begin
         resp       <= resp_next;
         // Open drain: only the enable moves, the level stays low
         sda_o      <= 1'b0;
         sda_oe     <= m_oe;
         slave_mode <= m_addressed; // R5
      end
   end

endmodule
`default_nettype wire

// ---- testbench/i2ca_monitor.sv ----
// Checker for the address and rate register block ports
`timescale 1ns/100ps
`default_nettype none
module i2ca_monitor (
   input wire logic                 clk,
   input wire logic                 reset_n,
   input wire i2ca_pkg::i2ca_req_t  req,
   input wire i2ca_pkg::i2ca_resp_t resp,
   input wire logic                 sda_o,
   input wire logic                 sda_oe,
   input wire logic                 slave_mode,
   input wire logic                 bit_tick
);
   import i2ca_pkg::*;
   logic mapped;
   assign mapped = req.ofs inside {12'h280, 12'h284, 12'h288, 12'h28c, 12'h290};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence own_read_s;
      req.sel && !req.wr && req.ofs == 12'h280;
   endsequence
   sequence rate_read_s;
      req.sel && !req.wr && req.ofs == 12'h284;
   endsequence
   sequence ack_begin_s;
      $rose(sda_oe);
   endsequence
   ack_each_a: assert property (req.sel |=> resp.ack)
      else $error("no answer after request");
   ack_cause_a: assert property (!req.sel |=> !resp.ack)
      else $error("answer without request");
   ext_refuse_a: assert property (req.sel && req.ext && !mapped |=> resp.err && resp.rdata == 0)
      else $error("outside access not refused");
   map_allow_a: assert property (req.sel && mapped |=> !resp.err)
      else $error("register access refused");
   low_bytes_a: assert property (resp.ack |-> resp.rdata[23:0] == 24'h0)
      else $error("lower bytes not zero");
   own_bit0_a: assert property (own_read_s |=> resp.rdata[24] == 1'b0)
      else $error("own address bit 0 set");
   rate_top_a: assert property (rate_read_s |=> resp.rdata[31:30] == 2'b00)
      else $error("rate code top bits set");
   no_drive_a: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   oe_slave_a: assert property (sda_oe |-> slave_mode)
      else $error("data line pulled outside slave mode");
   tick_gap_a: assert property (bit_tick |=> !bit_tick [*8])
      else $error("bit tick too close");
   ack_slave_a: assert property (ack_begin_s |=> slave_mode)
      else $error("ack without slave mode");
endmodule
bind i2ca_top i2ca_monitor mon (.clk(clk), .reset_n(reset_n), .req(req), .resp(resp),
   .sda_o(sda_o), .sda_oe(sda_oe), .slave_mode(slave_mode), .bit_tick(bit_tick));
`default_nettype wire

// ---- testbench/i2ca_bus_master.sv ----
// Bus master model pulling the serial lines through open-drain outputs
`timescale 1ns/100ps
`default_nettype none
module i2ca_bus_master #(
   parameter int HP = 8
) (
   input  wire logic clk,
   input  wire logic sda,
   output var  logic scl_low,
   output var  logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic hold();
      repeat (HP) @(posedge clk);
   endtask
   // Also a repeated start, as the clock is left low
   task automatic start_cond();
      sda_low <= 1'b0;
      hold();
      scl_low <= 1'b0;
      hold();
      sda_low <= 1'b1;
      hold();
      scl_low <= 1'b1;
      hold();
   endtask
   // Data moves only a full step after the clock falls
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low <= ~b[i];
         hold();
         scl_low <= 1'b0;
         hold();
         scl_low <= 1'b1;
         hold();
      end
      sda_low <= 1'b0;
      hold();
      scl_low <= 1'b0;
      hold();
      ack = sda;
      scl_low <= 1'b1;
      hold();
   endtask
   task automatic stop_cond();
      sda_low <= 1'b1;
      hold();
      scl_low <= 1'b0;
      hold();
      sda_low <= 1'b0;
      hold();
   endtask
endmodule
`default_nettype wire

// ---- testbench/i2c_addr_and_bit_rate_divider_tb_top.sv ----
// Testbench for the address and rate register block
`timescale 1ns/100ps
`default_nettype none
module i2c_addr_and_bit_rate_divider_tb_top;
   import i2ca_pkg::*;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   i2ca_req_t  req = '0;
   i2ca_resp_t resp;
   logic       sda_o;
   logic       sda_oe;
   logic       slave_mode;
   logic       bit_tick;
   logic       scl_low;
   logic       sda_low;
   wire logic  scl_w;
   wire logic  sda_w;
   int         n_fail = 0;
   int         n_checks = 0;
   int         divs [64] = '{28, 30, 34, 40, 44, 48, 56, 68, 80, 88, 104, 128, 144, 160, 192,
      240, 288, 320, 384, 480, 576, 640, 768, 960, 1152, 1280, 1536, 1920, 2304, 2560, 3072,
      3840, 20, 22, 24, 26, 28, 32, 36, 40, 48, 56, 64, 72, 80, 96, 112, 128, 160, 192, 224,
      256, 320, 384, 448, 512, 640, 768, 896, 1024, 1280, 1536, 1792, 2048};
   // Pull-ups: a released line reads high
   assign scl_w = ~scl_low;
   assign sda_w = ~(sda_low | sda_oe);
   always #25 clk = ~clk;
   i2ca_top dut (.clk(clk), .reset_n(reset_n), .req(req), .resp(resp), .scl_i(scl_w),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .slave_mode(slave_mode),
      .bit_tick(bit_tick));
   i2ca_bus_master mst (.clk(clk), .sda(sda_w), .scl_low(scl_low), .sda_low(sda_low));
   task automatic give_verdict();
      if (n_fail == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic e, input logic [11:0] a,
                      input logic [31:0] wd, output i2ca_resp_t r);
      @(posedge clk);
      req <= '{sel: 1'b1, wr: w, ext: e, ofs: a, wdata: wd};
      @(posedge clk);
      req.sel <= 1'b0;
      #1 r = resp;
   endtask
   task automatic wr(input logic e, input logic [11:0] a, input logic [7:0] b);
      i2ca_resp_t r;
      bus(1'b1, e, a, {b, 24'h5a5a5a}, r);
   endtask
   task automatic rd_chk(input logic e, input logic [11:0] a, input logic [7:0] x,
                         input logic er);
      i2ca_resp_t r;
      bus(1'b0, e, a, 32'hffffffff, r);
      chk({r.ack, r.err, r.rdata}, {1'b1, er, x, 24'h0});
   endtask
   task automatic wait_tick(output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (bit_tick !== 1'b1 && k < 5000);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 5; i++) begin
         rd_chk(1'b0, 12'h280 + 12'(4 * i), 8'h00, 1'b0);
      end
   endtask
   task automatic t_regs();
      wr(1'b0, 12'h280, 8'hff);
      rd_chk(1'b0, 12'h280, 8'hfe, 1'b0);
      wr(1'b1, 12'h284, 8'hff);
      rd_chk(1'b1, 12'h284, 8'h3f, 1'b0);
      wr(1'b1, 12'h290, 8'ha5);
      rd_chk(1'b0, 12'h290, 8'ha5, 1'b0);
      rd_chk(1'b1, 12'h294, 8'h00, 1'b1);
      rd_chk(1'b1, 12'h000, 8'h00, 1'b1);
      rd_chk(1'b0, 12'h294, 8'h00, 1'b0);
   endtask
   task automatic t_slave();
      logic a;
      wr(1'b1, 12'h280, 8'hb4);
      wr(1'b0, 12'h288, 8'h80);
      mst.start_cond();
      mst.send_byte(8'hb4, a);
      chk(34'(a), 34'h0);
      chk(34'(slave_mode), 34'h1);
      mst.send_byte(8'h3c, a);
      chk(34'(a), 34'h0);
      rd_chk(1'b0, 12'h28c, 8'he0, 1'b0);
      mst.stop_cond();
      chk(34'(slave_mode), 34'h0);
      rd_chk(1'b0, 12'h290, 8'h3c, 1'b0);
      mst.start_cond();
      mst.send_byte(8'hb6, a);
      chk(34'(a), 34'h1);
      chk(34'(slave_mode), 34'h0);
      mst.start_cond();
      mst.send_byte(8'hb5, a);
      chk(34'(a), 34'h0);
      mst.stop_cond();
   endtask
   task automatic t_rate();
      int k;
      int n;
      wr(1'b0, 12'h288, 8'h00);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         n += int'(bit_tick === 1'b1);
      end
      chk(34'(n), 34'h0);
      wr(1'b0, 12'h288, 8'h80);
      for (int c = 0; c < 64; c++) begin
         wr(1'b0, 12'h284, 8'(c));
         wait_tick(k);
         wait_tick(k);
         wait_tick(k);
         chk(34'(k), 34'(divs[c] / 2));
      end
   endtask
   initial begin
      // Rate sweep needs about 56k clocks; margin kept under 100k
      repeat (80000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_regs();
      t_slave();
      t_rate();
      give_verdict();
   end
endmodule
`default_nettype wire
